// file: hdl/port_pin_alternate_override.v
// Port A pin logic with alternate function overrides from the peripherals
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_defines.vh"

module port_pin_alternate_override
#(
  parameter WIDTH = `PORT_WIDTH
)
(
  // Clock and reset
  input  wire             clk_sys,
  input  wire             sys_rst,
  // Port register access, strobes shared by all pins
  input  wire             directionWrite,
  input  wire [WIDTH-1:0] directionWdata,
  input  wire             outputValueWrite,
  input  wire [WIDTH-1:0] outputValueWdata,
  input  wire             pinToggleWrite,
  input  wire [WIDTH-1:0] pinToggleWdata,
  output wire [WIDTH-1:0] directionBit,
  output wire [WIDTH-1:0] outputValueBit,
  output wire [WIDTH-1:0] pinInputBit,
  // Shared by all ports
  input  wire             globalPullupDisable,
  input  wire             sleepClamp,
  // Generic per-pin overrides from peripherals
  input  wire [WIDTH-1:0] pullupOverrideEn,
  input  wire [WIDTH-1:0] pullupOverrideVal,
  input  wire [WIDTH-1:0] directionOverrideEn,
  input  wire [WIDTH-1:0] directionOverrideVal,
  input  wire [WIDTH-1:0] valueOverrideEn,
  input  wire [WIDTH-1:0] valueOverrideVal,
  input  wire [WIDTH-1:0] toggleOverrideEn,
  input  wire [WIDTH-1:0] inputEnOverrideEn,
  input  wire [WIDTH-1:0] inputEnOverrideVal,
  // Converter reference selection
  input  wire             refSelectBit0,
  // Timer and serial interface outputs with their enables
  input  wire             timer0MatchBOut,
  input  wire             timer0MatchBEn,
  input  wire             timer1MatchAOut,
  input  wire             timer1MatchAEn,
  input  wire             timer1MatchBOut,
  input  wire             timer1MatchBEn,
  input  wire             serialDataOut,
  input  wire             serialDataOutEn,
  input  wire             serialClockOut,
  input  wire             serialClockOutEn,
  input  wire             serialDataLineOut,
  input  wire             serialDataLineOutEn,
  // Pads
  input  wire [WIDTH-1:0] padIn,
  output wire [WIDTH-1:0] padOut,
  output wire [WIDTH-1:0] padOe,
  output wire [WIDTH-1:0] padPullup,
  // Digital inputs to alternate functions, unsynchronised
  output wire [WIDTH-1:0] altRawDigitalInput,
  output wire [WIDTH-1:0] pinChangeSource,
  output wire             timer0CountSource,
  output wire             timer1CountSource,
  output wire             serialIfClockIn,
  output wire             serialDataIn,
  output wire             timer1CaptureIn,
  // Analog paths straight from the pads
  output wire [WIDTH-1:0] converterChannelIn,
  output wire             externalAnalogReference,
  output wire             comparatorPositiveIn,
  output wire             comparatorNegativeIn
);

  // ****************************************************************
  // Port registers
  // ****************************************************************
  reg  [WIDTH-1:0] direction_r;
  reg  [WIDTH-1:0] direction_nxt;
  reg  [WIDTH-1:0] outputValue_r;
  reg  [WIDTH-1:0] outputValue_nxt;

  // Merged overrides that reach the pin cells
  reg  [WIDTH-1:0] pullupOvEnAll;
  reg  [WIDTH-1:0] pullupOvValAll;
  reg  [WIDTH-1:0] dirOvEnAll;
  reg  [WIDTH-1:0] dirOvValAll;
  reg  [WIDTH-1:0] valOvEnAll;
  reg  [WIDTH-1:0] valOvValAll;

  wire [WIDTH-1:0] pullupEnable;
  wire [WIDTH-1:0] driverEnable;
  wire [WIDTH-1:0] driveValue;
  wire [WIDTH-1:0] inputEnable;
  wire [WIDTH-1:0] rawIn;
  wire [WIDTH-1:0] toggleMask;

  // ****************************************************************
  // Register update
  // ****************************************************************
  // Software toggle and the peripheral toggle both flip the bit; a
  // write and a toggle in the same cycle apply the write then the flip.
  assign toggleMask = (pinToggleWrite ? pinToggleWdata : {WIDTH{1'h0}})
                      | toggleOverrideEn;

  always @*
  begin
    direction_nxt = direction_r;
    if (directionWrite)
    begin
      direction_nxt = directionWdata;
    end
  end

  always @*
  begin
    outputValue_nxt = outputValue_r;
    if (outputValueWrite)
    begin
      outputValue_nxt = outputValueWdata;
    end
    outputValue_nxt = outputValue_nxt ^ toggleMask;
  end

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      direction_r   <= `DIRECTION_RESET;
      outputValue_r <= `OUTPUT_VALUE_RESET;
    end
    else
    begin
      direction_r   <= direction_nxt;
      outputValue_r <= outputValue_nxt;
    end
  end

  // ****************************************************************
  // Pin read synchroniser
  // ****************************************************************
  // The gated Schmitt output walks down a chain of stages and only the
  // last one is read, keeping metastability away from software. Each
  // stage adds a cycle of read latency, the price of that safety.
  localparam SYNC_STAGES = `PORT_SYNC_STAGES;
  localparam CHAIN_BITS  = SYNC_STAGES * WIDTH;

  reg  [CHAIN_BITS-1:0] syncChain_r;
  integer               stageIdx;

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      syncChain_r <= {SYNC_STAGES{`PIN_SYNC_RESET}};
    end
    else
    begin
      syncChain_r[WIDTH-1:0] <= rawIn;
      for (stageIdx = 1; stageIdx < SYNC_STAGES; stageIdx = stageIdx + 1)
      begin
        syncChain_r[stageIdx*WIDTH +: WIDTH] <= syncChain_r[(stageIdx-1)*WIDTH +: WIDTH];
      end
    end
  end

  assign directionBit   = direction_r;
  assign outputValueBit = outputValue_r;
  assign pinInputBit    = syncChain_r[CHAIN_BITS-1 -: WIDTH];

  // ****************************************************************
  // Alternate function merge for port A
  // ****************************************************************
  // Peripheral owners produce the enables; here they only replace bits of
  // the generic per-pin vectors so one cell type serves every pin.
  // Pins 1 to 3 take no merge: their alternate functions only listen.
  always @*
  begin
    pullupOvEnAll  = pullupOverrideEn;
    pullupOvValAll = pullupOverrideVal;
    // External reference on pin 0: pull-up forced off
    if (refSelectBit0)
    begin
      pullupOvEnAll[`PIN_EXT_REFERENCE]  = 1'h1;
      pullupOvValAll[`PIN_EXT_REFERENCE] = 1'h0;
    end
  end

  always @*
  begin
    dirOvEnAll  = directionOverrideEn;
    dirOvValAll = directionOverrideVal;
    // External reference on pin 0: driver forced off
    if (refSelectBit0)
    begin
      dirOvEnAll[`PIN_EXT_REFERENCE]  = 1'h1;
      dirOvValAll[`PIN_EXT_REFERENCE] = 1'h0;
    end
    // Pin 6: two-wire data line is open drain, the driver only pulls low
    if (serialDataLineOutEn)
    begin
      dirOvEnAll[`PIN_SERIAL_DIN]  = 1'h1;
      dirOvValAll[`PIN_SERIAL_DIN] = ~serialDataLineOut;
    end
  end

  always @*
  begin
    valOvEnAll  = valueOverrideEn;
    valOvValAll = valueOverrideVal;
    // Pin 0 carries the reference, so its value is parked low as well
    if (refSelectBit0)
    begin
      valOvEnAll[`PIN_EXT_REFERENCE]  = 1'h1;
      valOvValAll[`PIN_EXT_REFERENCE] = 1'h0;
    end
    // Pin 4: serial clock out, in three-wire and two-wire modes
    if (serialClockOutEn)
    begin
      valOvEnAll[`PIN_SERIAL_CLOCK]  = 1'h1;
      valOvValAll[`PIN_SERIAL_CLOCK] = serialClockOut;
    end
    // Pin 5: serial data out wins over timer 1 match B
    if (serialDataOutEn)
    begin
      valOvEnAll[`PIN_SERIAL_DOUT]  = 1'h1;
      valOvValAll[`PIN_SERIAL_DOUT] = serialDataOut;
    end
    else if (timer1MatchBEn)
    begin
      valOvEnAll[`PIN_SERIAL_DOUT]  = 1'h1;
      valOvValAll[`PIN_SERIAL_DOUT] = timer1MatchBOut;
    end
    // Pin 6: the open-drain data line drives low, else timer 1 match A
    if (serialDataLineOutEn)
    begin
      valOvEnAll[`PIN_SERIAL_DIN]  = 1'h1;
      valOvValAll[`PIN_SERIAL_DIN] = 1'h0;
    end
    else if (timer1MatchAEn)
    begin
      valOvEnAll[`PIN_SERIAL_DIN]  = 1'h1;
      valOvValAll[`PIN_SERIAL_DIN] = timer1MatchAOut;
    end
    // Pin 7: timer 0 match B
    if (timer0MatchBEn)
    begin
      valOvEnAll[`PIN_TIMER0_MATCH_B]  = 1'h1;
      valOvValAll[`PIN_TIMER0_MATCH_B] = timer0MatchBOut;
    end
  end

  // ****************************************************************
  // Per-pin override cells
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_pin
      pin_override_cell u_cell
      (
        .directionBit         (direction_r[gi]),
        .outputValueBit       (outputValue_r[gi]),
        .globalPullupDisable  (globalPullupDisable),
        .sleepClamp           (sleepClamp),
        .portReset            (sys_rst),
        .pullupOverrideEn     (pullupOvEnAll[gi]),
        .pullupOverrideVal    (pullupOvValAll[gi]),
        .directionOverrideEn  (dirOvEnAll[gi]),
        .directionOverrideVal (dirOvValAll[gi]),
        .valueOverrideEn      (valOvEnAll[gi]),
        .valueOverrideVal     (valOvValAll[gi]),
        .inputEnOverrideEn    (inputEnOverrideEn[gi]),
        .inputEnOverrideVal   (inputEnOverrideVal[gi]),
        .padSchmittIn         (padIn[gi]),
        .pullupEnable         (pullupEnable[gi]),
        .driverEnable         (driverEnable[gi]),
        .driveValue           (driveValue[gi]),
        .inputEnable          (inputEnable[gi]),
        .altRawDigitalInput   (rawIn[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Pad outputs
  // ****************************************************************
  // Pad controls are combinational so override changes and reset reach
  // the pad with no clock edge; reset tri-states even with clock stopped.
  assign padOe     = driverEnable;
  assign padOut    = driveValue & driverEnable;
  // The pull-up is not masked by the driver: an override must win over the
  // direction bit, and the generic code already keeps it off for outputs.
  assign padPullup = pullupEnable;

  // ****************************************************************
  // Digital inputs to peripherals
  // ****************************************************************
  // Unsynchronised on purpose; receivers must synchronise unless they
  // use the line as a clock.
  assign altRawDigitalInput = rawIn;
  assign pinChangeSource    = rawIn;
  assign timer0CountSource  = rawIn[`PIN_TIMER0_SOURCE];
  assign timer1CountSource  = rawIn[`PIN_SERIAL_CLOCK];
  assign serialIfClockIn    = rawIn[`PIN_SERIAL_CLOCK];
  assign serialDataIn       = rawIn[`PIN_SERIAL_DIN];
  assign timer1CaptureIn    = rawIn[`PIN_TIMER0_MATCH_B];

  // ****************************************************************
  // Analog paths
  // ****************************************************************
  // Digital model of a direct pad wire: no gating, no clamp, no sync.
  assign converterChannelIn      = padIn;
  assign externalAnalogReference = padIn[`PIN_EXT_REFERENCE];
  assign comparatorPositiveIn    = padIn[`PIN_CMP_POSITIVE];
  assign comparatorNegativeIn    = padIn[`PIN_CMP_NEGATIVE];

endmodule // port_pin_alternate_override

`default_nettype wire

// file: hdl/port_pin_defines.vh
// Constants for the port pin override block: widths, pin map, reset values
`ifndef PORT_PIN_DEFINES_VH
`define PORT_PIN_DEFINES_VH

// ****************************************************************
// Port geometry
// ****************************************************************
`define PORT_WIDTH          8
`define PORT_SYNC_STAGES    2

// ****************************************************************
// Reset values of the port register bits
// ****************************************************************
`define DIRECTION_RESET     8'h00
`define OUTPUT_VALUE_RESET  8'h00
`define PIN_SYNC_RESET      8'h00

// ****************************************************************
// Alternate function pin positions on port A
// ****************************************************************
`define PIN_EXT_REFERENCE   0
`define PIN_CMP_POSITIVE    1
`define PIN_CMP_NEGATIVE    2
`define PIN_TIMER0_SOURCE   3
`define PIN_SERIAL_CLOCK    4
`define PIN_SERIAL_DOUT     5
`define PIN_SERIAL_DIN      6
`define PIN_TIMER0_MATCH_B  7

// ****************************************************************
// Pull-up enable code on {direction, output value, global disable}
// ****************************************************************
`define PULLUP_ON_CODE      3'h2

`endif

// file: hdl/pin_override_cell.v
// One pad's override selection: pull-up, driver, value, input enable
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_defines.vh"

module pin_override_cell
(
  // Port register bits of this pin
  input  wire directionBit,
  input  wire outputValueBit,
  // Shared controls
  input  wire globalPullupDisable,
  input  wire sleepClamp,
  input  wire portReset,
  // Overrides from the owning peripheral
  input  wire pullupOverrideEn,
  input  wire pullupOverrideVal,
  input  wire directionOverrideEn,
  input  wire directionOverrideVal,
  input  wire valueOverrideEn,
  input  wire valueOverrideVal,
  input  wire inputEnOverrideEn,
  input  wire inputEnOverrideVal,
  // Pad side
  input  wire padSchmittIn,
  output wire pullupEnable,
  output wire driverEnable,
  output wire driveValue,
  output wire inputEnable,
  output wire altRawDigitalInput
);

  wire pullupNormal;
  wire driverSel;

  // ****************************************************************
  // Pull-up and driver
  // ****************************************************************
  assign pullupNormal = ({directionBit, outputValueBit, globalPullupDisable} == `PULLUP_ON_CODE);
  // Reset gates the pad combinationally, so no clock edge is needed
  assign pullupEnable = ~portReset & (pullupOverrideEn ? pullupOverrideVal : pullupNormal);
  assign driverSel    = directionOverrideEn ? directionOverrideVal : directionBit;
  assign driverEnable = ~portReset & driverSel;
  assign driveValue   = valueOverrideEn ? valueOverrideVal : outputValueBit;

  // ****************************************************************
  // Digital input enable and the raw input
  // ****************************************************************
  assign inputEnable = inputEnOverrideEn ? inputEnOverrideVal : ~sleepClamp;
  // Clamped low at the trigger input when disabled; taken before any synchroniser
  assign altRawDigitalInput = padSchmittIn & inputEnable;

endmodule // pin_override_cell

`default_nettype wire

// file: bench/port_pin_override_monitor.sv
// Checker for the port pin override block, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module port_pin_override_monitor #(parameter W = 8)
(
  // Clock, reset and register side
  input wire logic         clk_sys,
  input wire logic         sys_rst,
  input wire logic         outputValueWrite,
  input wire logic         pinToggleWrite,
  input wire logic [W-1:0] directionBit,
  input wire logic [W-1:0] outputValueBit,
  input wire logic [W-1:0] pinInputBit,
  // Shared levels and per-pin overrides
  input wire logic         globalPullupDisable,
  input wire logic         sleepClamp,
  input wire logic         refSelectBit0,
  input wire logic [W-1:0] pullupOverrideEn,
  input wire logic [W-1:0] pullupOverrideVal,
  input wire logic [W-1:0] directionOverrideEn,
  input wire logic [W-1:0] directionOverrideVal,
  input wire logic [W-1:0] valueOverrideEn,
  input wire logic [W-1:0] valueOverrideVal,
  input wire logic [W-1:0] toggleOverrideEn,
  input wire logic [W-1:0] inputEnOverrideEn,
  input wire logic [W-1:0] inputEnOverrideVal,
  // Pads
  input wire logic [W-1:0] padIn,
  input wire logic [W-1:0] padOut,
  input wire logic [W-1:0] padOe,
  input wire logic [W-1:0] padPullup,
  input wire logic [W-1:0] altRawDigitalInput
);
  // ****************************************************************
  // Pins 1 to 3 have no peripheral merge, so the generic selection shows there unmixed
  // ****************************************************************
  wire [W-1:0] oeSel = directionOverrideEn & directionOverrideVal | ~directionOverrideEn & directionBit;
  wire [W-1:0] valSel = valueOverrideEn & valueOverrideVal | ~valueOverrideEn & outputValueBit;
  wire [W-1:0] puSel = pullupOverrideEn & pullupOverrideVal
                     | ~pullupOverrideEn & ~directionBit & outputValueBit & {W{~globalPullupDisable}};
  wire [W-1:0] ieSel = inputEnOverrideEn & inputEnOverrideVal | ~inputEnOverrideEn & {W{~sleepClamp}};

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  property p_pullup;
    padPullup[3:1] == puSel[3:1];
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up mismatch");
  property p_drv;
    padOe[3:1] == oeSel[3:1];
  endproperty
  a_drv: assert property (p_drv) else $error("driver enable mismatch");
  property p_val;
    padOut[3:1] == (oeSel[3:1] & valSel[3:1]);
  endproperty
  a_val: assert property (p_val) else $error("pad value mismatch");
  property p_input;
    altRawDigitalInput == (padIn & ieSel);
  endproperty
  a_input: assert property (p_input) else $error("input enable mismatch");
  property p_ref0;
    refSelectBit0 |-> !padOe[0] && !padPullup[0];
  endproperty
  a_ref0: assert property (p_ref0) else $error("pin 0 not released");
  property p_toggle;
    (|toggleOverrideEn) && !outputValueWrite && !pinToggleWrite
      |=> outputValueBit == ($past(outputValueBit) ^ $past(toggleOverrideEn));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle override mismatch");
  property p_sync;
    !$past(sys_rst) && !$past(sys_rst, 2) |-> pinInputBit == $past(altRawDigitalInput, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("pin read delay mismatch");
  property p_tristate;
    disable iff (1'h0) sys_rst |-> padOe == 0 && padPullup == 0;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pad active in reset");
endmodule // port_pin_override_monitor

bind port_pin_alternate_override port_pin_override_monitor #(.W(WIDTH)) i_port_pin_override_monitor (.*);
`default_nettype wire

// file: bench/peripheral_override_model.sv
// Behavioural model of the peripherals that own the pin overrides
`timescale 1ns/1ps
`default_nettype none

module peripheral_override_model
(
  // Clock and bench request: override kinds, pins, values
  input  wire logic       clk_sys,
  input  wire logic [4:0] kindSel,
  input  wire logic [7:0] pinMask,
  input  wire logic [7:0] valPat,
  // Overrides towards the port
  output logic      [7:0] pullupOverrideEn,
  output logic      [7:0] pullupOverrideVal,
  output logic      [7:0] directionOverrideEn,
  output logic      [7:0] directionOverrideVal,
  output logic      [7:0] valueOverrideEn,
  output logic      [7:0] valueOverrideVal,
  output logic      [7:0] inputEnOverrideEn,
  output logic      [7:0] inputEnOverrideVal,
  output logic      [7:0] toggleOverrideEn,
  // Raw input and its local resynchronised copy
  input  wire logic [7:0] altRawDigitalInput,
  output logic      [7:0] rawSync_r
);
  logic [7:0] rawMeta_r;

  // Each peripheral drives its own enable on the pinMask pins; all but toggle take their value from valPat
  assign pullupOverrideEn = kindSel[0] ? pinMask : 8'h00;
  assign pullupOverrideVal = valPat;
  assign directionOverrideEn = kindSel[1] ? pinMask : 8'h00;
  assign directionOverrideVal = valPat;
  assign valueOverrideEn = kindSel[2] ? pinMask : 8'h00;
  assign valueOverrideVal = valPat;
  assign inputEnOverrideEn = kindSel[3] ? pinMask : 8'h00;
  assign inputEnOverrideVal = valPat;
  assign toggleOverrideEn = kindSel[4] ? pinMask : 8'h00;

  // The pad input arrives unsynchronised, so this consumer adds two flops
  always_ff @(posedge clk_sys)
    {rawSync_r, rawMeta_r} <= {rawMeta_r, altRawDigitalInput};
endmodule // peripheral_override_model
`default_nettype wire

// file: bench/port_pin_alternate_override_tb_top.sv
// Self-checking testbench for the port pin override block
`timescale 1ns/1ps
`default_nettype none

module port_pin_alternate_override_tb_top;
  logic        clk_sys, sys_rst, directionWrite, outputValueWrite, pinToggleWrite;
  logic        globalPullupDisable, sleepClamp, refSelectBit0;
  logic  [7:0] directionWdata, outputValueWdata, pinToggleWdata, padIn, pinMask, valPat;
  logic  [4:0] kindSel;
  logic [11:0] alt;
  wire         timer0MatchBOut, timer0MatchBEn, timer1MatchAOut, timer1MatchAEn, timer1MatchBOut, timer1MatchBEn;
  wire         serialDataOut, serialDataOutEn, serialClockOut, serialClockOutEn;
  wire         serialDataLineOut, serialDataLineOutEn;
  wire   [7:0] directionBit, outputValueBit, pinInputBit, padOut, padOe, padPullup, altRawDigitalInput;
  wire   [7:0] pinChangeSource, converterChannelIn, rawSync_r, pullupOverrideEn, pullupOverrideVal;
  wire   [7:0] directionOverrideEn, directionOverrideVal, valueOverrideEn, valueOverrideVal;
  wire   [7:0] toggleOverrideEn, inputEnOverrideEn, inputEnOverrideVal;
  wire         timer0CountSource, timer1CountSource, serialIfClockIn, serialDataIn, timer1CaptureIn;
  wire         externalAnalogReference, comparatorPositiveIn, comparatorNegativeIn;
  int          errorCnt, nCompared, cycles;

  assign {serialDataLineOutEn, serialDataLineOut, serialClockOutEn, serialClockOut, serialDataOutEn, serialDataOut,
          timer1MatchBEn, timer1MatchBOut, timer1MatchAEn, timer1MatchAOut, timer0MatchBEn, timer0MatchBOut} = alt;

  port_pin_alternate_override #(.WIDTH(8)) i_port_pin_alternate_override (.*);
  peripheral_override_model i_peripheral_override_model (.*);

  // ****************************************************************
  // Clock, timeout and shared tasks
  // ****************************************************************
  initial
  begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errorCnt++;
      giveVerdict();
    end
  end

  task automatic giveVerdict();
    if (errorCnt == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic setRegs(input logic [7:0] d, input logic [7:0] o);
    @(negedge clk_sys);
    directionWrite = 1'h1;
    directionWdata = d;
    outputValueWrite = 1'h1;
    outputValueWdata = o;
    @(negedge clk_sys);
    directionWrite = 1'h0;
    outputValueWrite = 1'h0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic testPullupTable();
    for (int c = 0; c < 8; c++)
    begin
      setRegs({8{c[2]}}, {8{c[1]}});
      globalPullupDisable = c[0];
      #1;
      check(padPullup, (c == 2) ? 8'hFF : 8'h00);
      check(padOe, {8{c[2]}});
      check(padOut, {8{c[2] & c[1]}});
    end
    globalPullupDisable = 1'h0;
  endtask

  task automatic testOverrides();
    logic [7:0] ov;
    setRegs(8'h96, 8'h3C);
    check(padPullup, 8'h28);
    sleepClamp = 1'h1;
    padIn = 8'hF5;
    kindSel = 5'h0F;
    pinMask = 8'h5A;
    valPat = 8'h33;
    ov = 8'h5A & 8'h33;
    #1;
    check(padOe, ov | 8'hA5 & 8'h96);
    check(padOut, (ov | 8'hA5 & 8'h96) & (ov | 8'hA5 & 8'h3C));
    check(padPullup, ov | 8'hA5 & 8'h69 & 8'h3C);
    check(altRawDigitalInput, 8'hF5 & ov);
    check(pinChangeSource, 8'hF5 & ov);
    check(converterChannelIn, 8'hF5);
    check({5'h00, externalAnalogReference, comparatorPositiveIn, comparatorNegativeIn}, 8'h05);
    kindSel = 5'h00;
    #1;
    check(altRawDigitalInput, 8'h00);
    sleepClamp = 1'h0;
  endtask

  task automatic testToggle();
    setRegs(8'hFF, 8'h00);
    kindSel = 5'h10;
    pinMask = 8'h81;
    @(negedge clk_sys);
    kindSel = 5'h00;
    check(outputValueBit, 8'h81);
    pinToggleWrite = 1'h1;
    pinToggleWdata = 8'h0F;
    @(negedge clk_sys);
    check(outputValueBit, 8'h8E);
    pinToggleWdata = 8'h11;
    outputValueWrite = 1'h1;
    outputValueWdata = 8'h30;
    @(negedge clk_sys);
    pinToggleWrite = 1'h0;
    outputValueWrite = 1'h0;
    check(padOut, 8'h21);
  endtask

  task automatic testSync();
    padIn = 8'h00;
    repeat (3) @(negedge clk_sys);
    padIn = 8'hA5;
    #1;
    check(altRawDigitalInput, 8'hA5);
    @(negedge clk_sys);
    check(pinInputBit, 8'h00);
    @(negedge clk_sys);
    check(pinInputBit, 8'hA5);
    check(rawSync_r, 8'hA5);
  endtask

  task automatic testRefPin0();
    setRegs(8'hFF, 8'hFF);
    refSelectBit0 = 1'h1;
    kindSel = 5'h07;
    pinMask = 8'h01;
    valPat = 8'h01;
    #1;
    check({5'h00, padOe[0], padPullup[0], padOut[0]}, 8'h00);
    refSelectBit0 = 1'h0;
    #1;
    check(padOe, 8'hFF);
    kindSel = 5'h00;
  endtask

  task automatic testAltPins();
    setRegs(8'hFF, 8'h00);
    padIn = 8'h98;
    alt = 12'h33F;
    #1;
    check(padOut, 8'hF0);
    check({3'h0, timer0CountSource, timer1CountSource, serialIfClockIn, serialDataIn, timer1CaptureIn}, 8'h1D);
    alt = 12'h3BF;
    #1;
    check(padOut, 8'hD0);
    alt = 12'hBBF;
    #1;
    check(padOut, 8'h90);
    alt = 12'hFBF;
    #1;
    check(padOe, 8'hBF);
    alt = 12'h000;
  endtask

  initial
  begin
    sys_rst = 1'h1;
    {directionWrite, outputValueWrite, pinToggleWrite, globalPullupDisable, sleepClamp, refSelectBit0} = 6'h00;
    {directionWdata, outputValueWdata, pinToggleWdata, padIn} = 32'h0000_0000;
    alt = 12'h000;
    // Overrides that ask for drive and pull-up must still lose to reset
    kindSel = 5'h07;
    pinMask = 8'hFF;
    valPat = 8'hFF;
    #1;
    check(padOe | padPullup, 8'h00);
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'h0;
    kindSel = 5'h00;
    check(directionBit | outputValueBit, 8'h00);
    // Comparator pins left as inputs with pull-up off, as software should
    padIn = 8'h06;
    #1;
    check({4'h0, comparatorPositiveIn, comparatorNegativeIn, padOe[2:1] | padPullup[2:1]}, 8'h0C);
    testPullupTable();
    testOverrides();
    testToggle();
    testSync();
    testRefPin0();
    testAltPins();
    giveVerdict();
  end
endmodule // port_pin_alternate_override_tb_top
`default_nettype wire
